//--- common/vtrc_pkg.sv
// Package: register map, field positions and timing for vector table relocation control
`default_nettype none
package vtrc_pkg;
    // Register byte addresses on the Avalon-MM slave (two aligned words)
    localparam logic [3:0] GIC_ADDR       = 4'h0;
    localparam logic [3:0] STATUS_ADDR    = 4'h4;
    // Field positions inside the control register
    localparam int         SEL_BIT        = 1;
    localparam int         UNLOCK_BIT     = 0;
    localparam logic [7:0] GIC_RESET      = 8'h00;
    // Unlock window in enabled system clock cycles (clk_en high)
    localparam int         UNLOCK_CYCLES  = 4;
    localparam logic [2:0] UNLOCK_LOAD    = 3'h4;
    // Boot section start word addresses per boot size fuse code
    localparam logic [15:0] BOOT_START_0  = 16'h1c00;
    localparam logic [15:0] BOOT_START_1  = 16'h1e00;
    localparam logic [15:0] BOOT_START_2  = 16'h1f00;
    localparam logic [15:0] BOOT_START_3  = 16'h1f80;
    localparam logic [15:0] APP_START     = 16'h0000;

    typedef struct packed {
        logic [15:0] base;
        logic        blocked;
    } vtrc_vec_t;

    typedef enum logic [1:0] {
        VTRC_IDLE   = 2'b00,
        VTRC_OPEN   = 2'b01,
        VTRC_FINISH = 2'b11
    } vtrc_state_t;
endpackage : vtrc_pkg
`default_nettype wire

//--- rtl/vtrc_ctrl.sv
// Vector table relocation control with timed unlock and boot lock blocking
`default_nettype none
// How it works
// - Select bit zero places the vector base at the start of program memory.
// - Select bit one places the vector base at the boot section start chosen by the fuses.
// - The select bit changes only on a write while the unlock bit is set.
// - Interrupts are blocked from the unlock cycle until the instruction after the select write.
// - Without a select write the block lasts exactly four cycles after unlock.
// - The automatic block never alters the global interrupt enable flag.
// - Hardware clears the unlock bit on a select write or after four cycles.
// - Boot vectors with the app-side lock block interrupts while running application code.
// - App vectors with the boot-side lock block interrupts while running boot code.
module vtrc_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [1:0]        boot_size_fuses,
    input  wire logic              app_side_boot_lock,
    input  wire logic              boot_side_boot_lock,
    input  wire logic              exec_in_boot,
    input  wire logic              instr_done,
    input  wire logic              global_int_en,
    output vtrc_pkg::vtrc_vec_t    vec_out,
    output logic                   int_accept_en
);
    import vtrc_pkg::*;

    logic        sel_q;
    logic        unlock_run;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        hold_q;
    vtrc_state_t state_q;
    vtrc_state_t state_d;
    logic [1:0]  fuse_s1_q;
    logic [1:0]  fuse_s2_q;
    logic [1:0]  lock_s1_q;
    logic [1:0]  lock_s2_q;
    vtrc_vec_t   vec_q;
    logic        acc_q;

    function automatic logic [15:0] boot_start(input logic [1:0] code);
        case (code)
            2'h0:    boot_start = BOOT_START_0;
            2'h1:    boot_start = BOOT_START_1;
            2'h2:    boot_start = BOOT_START_2;
            default: boot_start = BOOT_START_3;
        endcase
    endfunction : boot_start

    // Bus decode: one wait cycle, then a single-cycle answer
    wire req        = (avs_read | avs_write) & ~ack_q;
    wire hit_gic    = (avs_address == GIC_ADDR);
    wire hit_stat   = (avs_address == STATUS_ADDR);
    wire wr_gic     = avs_write & ack_q & hit_gic & avs_byteenable[0];
    wire wr_unlock  = wr_gic & avs_writedata[UNLOCK_BIT];
    wire wr_select  = wr_gic & ~avs_writedata[UNLOCK_BIT] & unlock_run;
    wire [1:0] lk   = lock_s2_q;
    wire fuse_blk   = sel_q ? (lk[0] & ~exec_in_boot)
                            : (lk[1] & exec_in_boot);
    wire seq_blk    = unlock_run | (state_q != VTRC_IDLE) | wr_unlock;
    wire [7:0] gic_view = {6'h00, sel_q, unlock_run};
    wire [31:0] rd_mux  = hit_gic  ? {24'h000000, gic_view} :
                          hit_stat ? {30'h0, int_accept_en, fuse_blk} : 32'h0;

    vtrc_unlock_timer u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .start   (wr_unlock),
        .stop    (wr_select),
        .running (unlock_run)
    );

    // Hold the block through the instruction after the select write
    always_comb begin
        state_d = state_q;
        case (state_q)
            VTRC_IDLE:   if (wr_select) state_d = VTRC_OPEN;
            VTRC_OPEN:   if (instr_done) state_d = VTRC_FINISH;
            VTRC_FINISH: if (instr_done) state_d = VTRC_IDLE;
            default:     state_d = VTRC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_q     <= GIC_RESET[SEL_BIT];
            state_q   <= VTRC_IDLE;
            ack_q     <= 1'b0;
            rdata_q   <= 32'h0;
            hold_q    <= 1'b1;
            fuse_s1_q <= 2'h0;
            fuse_s2_q <= 2'h0;
            lock_s1_q <= 2'h0;
            lock_s2_q <= 2'h0;
            vec_q     <= '0;
            acc_q     <= 1'b0;
        end else if (clk_en) begin
            fuse_s1_q <= boot_size_fuses;
            fuse_s2_q <= fuse_s1_q;
            lock_s1_q <= {boot_side_boot_lock, app_side_boot_lock};
            lock_s2_q <= lock_s1_q;
            ack_q     <= req;
            hold_q    <= ~req;
            rdata_q   <= rd_mux;
            state_q   <= state_d;
            if (wr_select) begin
                sel_q <= avs_writedata[SEL_BIT];
            end
            vec_q.base    <= sel_q ? boot_start(fuse_s2_q) : APP_START;
            vec_q.blocked <= seq_blk | fuse_blk;
            // Enable flag is only read, never written here
            acc_q <= global_int_en & ~seq_blk & ~fuse_blk;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = hold_q;
    assign vec_out         = vec_q;
    assign int_accept_en   = acc_q;

    // Window left alone for four enabled cycles must close on the fifth
    a_unlock_len: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_unlock) ##1 (clk_en && !wr_unlock && !wr_select)[*4] |=> !unlock_run)
        else $error("unlock window length wrong");

    a_unlock_set: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_unlock) |=> unlock_run)
        else $error("unlock window not opened");

    a_unlock_full: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_unlock) ##1 (clk_en && !wr_select)[*3] |-> unlock_run)
        else $error("unlock window closed early");
    a_sel_locked: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !unlock_run) |=> $stable(sel_q) || $past(wr_unlock))
        else $error("select changed without unlock");
    a_seq_blocks: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && unlock_run) |=> !acc_q)
        else $error("interrupt accepted during unlock");
    a_sel_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_select && !wr_unlock) |=> !unlock_run)
        else $error("unlock not cleared by select write");
    a_app_base: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !sel_q) |=> vec_q.base == APP_START)
        else $error("app base wrong");
    a_boot_base: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && sel_q) |=> vec_q.base == boot_start($past(fuse_s2_q)))
        else $error("boot base wrong");
    a_app_lock: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && sel_q && lk[0] && !exec_in_boot) |=> !acc_q)
        else $error("app lock not blocking");
    a_boot_lock: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !sel_q && lk[1] && exec_in_boot) |=> !acc_q)
        else $error("boot lock not blocking");

    // Global enable gates acceptance but is never written back
    a_gie_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !global_int_en) |=> !acc_q)
        else $error("accepted with global enable low");

    a_gie_pass: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && global_int_en && !seq_blk && !fuse_blk) |=> acc_q)
        else $error("acceptance blocked without cause");

    a_sel_write: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_select) |=> sel_q == $past(avs_writedata[SEL_BIT]))
        else $error("select write not taken");

    a_fsm_enter: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && wr_select && state_q == VTRC_IDLE) |=> state_q == VTRC_OPEN)
        else $error("post write hold not entered");

    a_open_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == VTRC_OPEN) |=> !acc_q)
        else $error("accepted before write retired");

    a_finish_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && state_q == VTRC_FINISH) |=> !acc_q)
        else $error("accepted before next instruction retired");

    a_vec_block: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && fuse_blk) |=> vec_q.blocked)
        else $error("blocked flag missing");

    // Bus timing: exactly one wait cycle, idle shows waitrequest high
    a_wait_one: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && req) |=> !avs_waitrequest)
        else $error("answer not after one wait cycle");

    a_wait_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !req) |=> avs_waitrequest)
        else $error("waitrequest low without request");

    // Clock enable low must freeze the control state
    a_freeze_state: assert property (@(posedge sys_clk) disable iff (rst)
        (!clk_en) |=> $stable(sel_q) && $stable(state_q) && $stable(acc_q))
        else $error("state moved while frozen");
endmodule : vtrc_ctrl
`default_nettype wire

//--- rtl/vtrc_unlock_timer.sv
// Unlock window timer: counts the four-cycle change window
`default_nettype none
module vtrc_unlock_timer (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       start,
    input  wire logic       stop,
    output logic            running
);
    import vtrc_pkg::*;

    logic [2:0] cnt_q;

    assign running = (cnt_q != 3'h0);

    // Start wins over stop so a fresh unlock is never lost
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 3'h0;
        end else if (clk_en) begin
            if (start) begin
                cnt_q <= UNLOCK_LOAD;
            end else if (stop) begin
                cnt_q <= 3'h0;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule : vtrc_unlock_timer
`default_nettype wire

//--- tb/tb_top.sv
// Register bus bench for vector table relocation control
`default_nettype none
module tb_top;
    import vtrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, app_lock = 0, boot_lock = 0, in_boot = 0, done = 0;
    logic [1:0]  fuses = 2'h0;
    logic        clk_en = 1, gie = 1;
    vtrc_vec_t   vec;
    logic        accept;
    int          n_fail = 0, num_checks = 0, cyc = 0;
    logic [15:0] starts [4] = '{BOOT_START_0, BOOT_START_1, BOOT_START_2, BOOT_START_3};
    vtrc_ctrl dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .boot_size_fuses(fuses), .app_side_boot_lock(app_lock), .boot_side_boot_lock(boot_lock),
        .exec_in_boot(in_boot), .instr_done(done), .global_int_en(gie), .vec_out(vec),
        .int_accept_en(accept));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic final_report;
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Cuts a hang short; the whole sequence needs under two hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low, then idles one edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk("readdata", exp, q);
    endtask : rd
    task automatic wt(input int n, input logic exp);
        repeat (n) @(posedge sys_clk);
        #1 chk("int_accept_en", {31'h0, exp}, {31'h0, accept});
        // Back on an edge so the next stimulus lands there
        @(posedge sys_clk);
    endtask : wt
    task automatic retire;
        repeat (2) begin
            done <= 1'b1;
            @(posedge sys_clk);
            done <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : retire
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(GIC_ADDR, 32'h0);
        chk("base", {16'h0, APP_START}, {16'h0, vec.base});
        wt(1, 1'b1);
        gie <= 1'b0;
        wt(2, 1'b0);
        gie <= 1'b1;
        wt(2, 1'b1);
        bus(GIC_ADDR, 1'b1, 32'h2);
        rd(GIC_ADDR, 32'h0);
        rd(4'h8, 32'h0);
        bus(GIC_ADDR, 1'b1, 32'h1);
        wt(0, 1'b0);
        rd(GIC_ADDR, 32'h1);
        wt(6, 1'b1);
        rd(GIC_ADDR, 32'h0);
        bus(GIC_ADDR, 1'b1, 32'h1);
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(GIC_ADDR, 32'h1);
        wt(8, 1'b1);
        bus(GIC_ADDR, 1'b1, 32'h2);
        rd(GIC_ADDR, 32'h0);
        bus(GIC_ADDR, 1'b1, 32'h1);
        bus(GIC_ADDR, 1'b1, 32'h2);
        rd(GIC_ADDR, 32'h2);
        wt(8, 1'b0);
        retire();
        wt(3, 1'b1);
        for (int i = 0; i < 4; i++) begin
            fuses <= i[1:0];
            repeat (5) @(posedge sys_clk);
            chk("base", {16'h0, starts[i]}, {16'h0, vec.base});
        end
        app_lock <= 1'b1;
        wt(5, 1'b0);
        chk("blocked", 32'h1, {31'h0, vec.blocked});
        rd(STATUS_ADDR, 32'h1);
        in_boot <= 1'b1;
        wt(3, 1'b1);
        app_lock <= 1'b0;
        bus(GIC_ADDR, 1'b1, 32'h1);
        bus(GIC_ADDR, 1'b1, 32'h0);
        retire();
        chk("base", {16'h0, APP_START}, {16'h0, vec.base});
        boot_lock <= 1'b1;
        wt(5, 1'b0);
        in_boot <= 1'b0;
        wt(3, 1'b1);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
